/* logic/charger_ctrl_pkg.sv */
// Constants, types and timing counts shared by the charger status/output control block.
// Assumes one 10 MHz clock; every other unit is derived from it here.

package charger_ctrl_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

  localparam int unsigned FAULT_PULSE_NS = 128_000;
  localparam int unsigned FAULT_PULSE_CYC = FAULT_PULSE_NS / CLK_PERIOD_NS;

  localparam int unsigned SOFTSTART_NS = 100_000;
  localparam int unsigned SOFTSTART_CYC = (SOFTSTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned RESET_HOLD_MS = 4;
  localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * (CLK_HZ / 1000);

  localparam int unsigned AUX_CODE_W = 5;
  localparam int unsigned AUX_MV_W = 12;
  localparam logic [11:0] AUX_BASE_MV = 12'h0320;
  localparam logic [11:0] AUX_STEP_MV = 12'h0064;
  localparam logic [11:0] AUX_PASS_MV = 12'h0CE4;

  localparam int unsigned BUCK_SEL_W = 2;
  localparam int unsigned BUCK_CODE_W = 4;

  // Positions of the pin inputs inside the synchroniser vector
  localparam int unsigned PIN_UVLO = 0;
  localparam int unsigned PIN_SLP = 1;
  localparam int unsigned PIN_OVP = 2;
  localparam int unsigned PIN_BAT = 3;
  localparam int unsigned PIN_BTN = 4;
  localparam int unsigned PIN_CD = 5;
  localparam int unsigned PIN_AUX = 6;
  localparam int unsigned PIN_W = 7;
  // Button idles high, everything else low
  localparam logic [6:0] PIN_RESET = 7'h10;

  typedef enum logic [1:0] {
    AUX_PULLDOWN = 2'b00,
    AUX_LDO = 2'b01,
    AUX_LSW = 2'b10
  } aux_mode_t;

  typedef enum logic [1:0] {
    BUCK_OFF = 2'b00,
    BUCK_SOFT = 2'b01,
    BUCK_RUN = 2'b10
  } buck_state_t;

endpackage

/* logic/pin_sync.sv */
// Three-stage synchroniser for asynchronous pin levels.
// A change is accepted once the second and third stage agree.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic ref_clk, // Block clock
  input wire logic rst, // Synchronous reset, high
  input wire logic [WIDTH-1:0] pin_in, // Raw pin levels
  output logic [WIDTH-1:0] level_out // Filtered levels
);

  if (WIDTH < 1)
  begin : bad_width
    $error("pin_sync WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } sync_t;

  sync_t st_q;
  sync_t st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st_q.s2[i] == st_q.s3[i])
      begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_q <= '{s1: INIT, s2: INIT, s3: INIT, lvl: INIT};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.lvl;

endmodule // pin_sync

`default_nettype wire

/* logic/charger_status_output_ctrl.sv */
// Status pins, chip-disable handling, buck enable sequencing and aux output selection.
// Analog comparators arrive as asynchronous levels; charger state comes from same-clock logic.
`timescale 1ns/1ps
`default_nettype none

module charger_status_output_ctrl #(
  parameter int unsigned FAULT_PULSE_CYCLES = charger_ctrl_pkg::FAULT_PULSE_CYC,
  parameter int unsigned SOFTSTART_CYCLES = charger_ctrl_pkg::SOFTSTART_CYC,
  parameter int unsigned RESET_HOLD_CYCLES = charger_ctrl_pkg::RESET_HOLD_CYC
) (
  input wire logic ref_clk, // 10 MHz clock
  input wire logic rst, // Synchronous reset, high
  input wire logic vin_above_uvlo, // Pin: input above UVLO
  input wire logic vin_above_bat_slp, // Pin: input above battery plus sleep offset
  input wire logic vin_below_ovp, // Pin: input below OVP
  input wire logic battery_present, // Pin: battery detected
  input wire logic push_button_in_n, // Pin: push-button, low pressed
  input wire logic chip_disable_n, // Pin: chip-disable level when driven
  input wire logic chip_disable_driven, // Pin: host actively drives chip-disable
  input wire logic aux_output_pin_ctrl, // Pin: aux control, high on
  input wire logic startup_done, // Start-up sequence finished
  input wire logic startup_fault, // Start-up finished into a fault
  input wire logic charging_active, // Charge or recharge in progress
  input wire logic fault_event, // One-cycle fault strobe
  input wire logic aux_fault, // Fault blocking the aux output
  input wire logic status_pin_mirror_select, // Power-good mirrors the button
  input wire logic charge_status_int_en, // Show charging on interrupt pin
  input wire logic buck_output_enable, // Buck enable, test use only
  input wire logic [charger_ctrl_pkg::BUCK_SEL_W-1:0] buck_range_select, // Buck range field
  input wire logic [charger_ctrl_pkg::BUCK_CODE_W-1:0] buck_voltage_code, // Buck code field
  input wire logic aux_output_enable_bit, // Aux enable bit
  input wire logic [charger_ctrl_pkg::AUX_CODE_W-1:0] aux_output_voltage_code, // Aux code
  output logic power_good_n_o, // Power-good drive level
  output logic power_good_n_oe, // Power-good pulls low when high
  output logic int_n_o, // Interrupt drive level
  output logic int_n_oe, // Interrupt pulls low when high
  output logic button_mirror_mode, // Power-good shows the button
  output logic charge_enable, // Charger allowed
  output logic hiz_mode, // High-impedance mode
  output logic mid_power_rail_on, // Mid rail active
  output logic batfet_on, // Battery discharge FET on
  output logic buck_ref_on, // Buck reference powered
  output logic buck_soft_start, // Buck in soft start
  output logic buck_switching, // Buck switching
  output logic buck_discharge, // Buck output discharge on
  output logic [charger_ctrl_pkg::BUCK_SEL_W-1:0] buck_range_o, // Applied buck range
  output logic [charger_ctrl_pkg::BUCK_CODE_W-1:0] buck_code_o, // Applied buck code
  output logic [1:0] aux_mode, // aux_mode_t of aux output
  output logic [charger_ctrl_pkg::AUX_MV_W-1:0] aux_target_mv, // Aux regulation target
  output logic aux_pulldown_on // Aux discharge pull-down
);

  localparam int unsigned PW = $clog2(FAULT_PULSE_CYCLES + 1);
  localparam int unsigned SW = $clog2(SOFTSTART_CYCLES + 1);
  localparam int unsigned HW = $clog2(RESET_HOLD_CYCLES + 1);

  if (FAULT_PULSE_CYCLES < 1 || SOFTSTART_CYCLES < 1 || RESET_HOLD_CYCLES < 1)
  begin : bad_counts
    $error("charger_status_output_ctrl counts must be at least 1");
  end

  typedef struct packed {
    logic drive_lo;
    logic started_ok;
    logic started_bad;
    logic pg_low;
    logic int_low;
    logic [PW-1:0] pulse_cnt;
    logic [HW-1:0] hold_cnt;
    logic hold_done;
    logic sys_lock;
    logic en_prev;
    charger_ctrl_pkg::buck_state_t buck_st;
    logic [SW-1:0] soft_cnt;
    logic buck_ref;
    logic buck_soft;
    logic buck_sw;
    logic buck_dis;
    logic [charger_ctrl_pkg::BUCK_SEL_W-1:0] buck_sel;
    logic [charger_ctrl_pkg::BUCK_CODE_W-1:0] buck_code;
    logic mirror;
    logic chg_en;
    logic hiz;
    logic mid_on;
    logic batfet;
    charger_ctrl_pkg::aux_mode_t aux_md;
    logic [charger_ctrl_pkg::AUX_MV_W-1:0] aux_mv;
    logic aux_pd;
  } ctrl_t;

  ctrl_t st_q;
  ctrl_t st_d;

  logic [charger_ctrl_pkg::PIN_W-1:0] pin_raw;
  logic [charger_ctrl_pkg::PIN_W-1:0] pin_lvl;
  logic cd_pin;
  logic vin_valid;
  logic btn_low;
  logic cd_low;
  logic aux_pin;
  logic bat_only;

  // Weak internal pull-down: a floating chip-disable reads low
  assign cd_pin = chip_disable_driven & chip_disable_n;

  assign pin_raw = {aux_output_pin_ctrl, cd_pin, push_button_in_n, battery_present,
                    vin_below_ovp, vin_above_bat_slp, vin_above_uvlo};

  pin_sync #(
    .WIDTH(charger_ctrl_pkg::PIN_W),
    .INIT(charger_ctrl_pkg::PIN_RESET)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(pin_raw),
    .level_out(pin_lvl)
  );

  function automatic logic [charger_ctrl_pkg::AUX_MV_W-1:0] aux_mv_of(
    input logic [charger_ctrl_pkg::AUX_CODE_W-1:0] code
  );
    logic [charger_ctrl_pkg::AUX_MV_W-1:0] ext;
    ext = {{(charger_ctrl_pkg::AUX_MV_W - charger_ctrl_pkg::AUX_CODE_W){1'b0}}, code};
    aux_mv_of = charger_ctrl_pkg::AUX_MV_W'(charger_ctrl_pkg::AUX_BASE_MV
                + ext * charger_ctrl_pkg::AUX_STEP_MV);
  endfunction

  assign vin_valid = pin_lvl[charger_ctrl_pkg::PIN_UVLO] & pin_lvl[charger_ctrl_pkg::PIN_SLP]
                     & pin_lvl[charger_ctrl_pkg::PIN_OVP];
  assign btn_low = ~pin_lvl[charger_ctrl_pkg::PIN_BTN];
  assign cd_low = ~pin_lvl[charger_ctrl_pkg::PIN_CD];
  assign aux_pin = pin_lvl[charger_ctrl_pkg::PIN_AUX];
  assign bat_only = pin_lvl[charger_ctrl_pkg::PIN_BAT] & ~vin_valid;

  always_comb
  begin
    st_d = st_q;
    st_d.drive_lo = 1'b0;

    // Start-up verdict is taken once and kept until reset
    if (startup_done && !st_q.started_ok && !st_q.started_bad)
    begin
      if (startup_fault)
      begin
        st_d.started_bad = 1'b1;
      end
      else
      begin
        st_d.started_ok = 1'b1;
      end
    end

    // Power-good, optionally mirroring the button
    st_d.mirror = status_pin_mirror_select;
    if (!st_q.started_ok)
    begin
      st_d.pg_low = 1'b0;
    end
    else if (status_pin_mirror_select)
    begin
      st_d.pg_low = btn_low;
    end
    else
    begin
      st_d.pg_low = vin_valid;
    end

    // Fault pulse: a new fault restarts a full-length pulse
    if (fault_event && st_q.started_ok)
    begin
      st_d.pulse_cnt = PW'(FAULT_PULSE_CYCLES);
    end
    else if (st_q.pulse_cnt != '0)
    begin
      st_d.pulse_cnt = st_q.pulse_cnt - PW'(1);
    end

    // Charging shows only when enabled; done or disabled charge drops the hold
    st_d.int_low = st_q.started_ok
                   && ((st_d.pulse_cnt != '0)
                       || (charging_active && charge_status_int_en && st_q.chg_en));

    // Chip-disable and supply decide charging and high-impedance mode
    st_d.chg_en = vin_valid && cd_low;
    st_d.hiz = bat_only && cd_low;
    st_d.mid_on = vin_valid || (bat_only && cd_low);
    st_d.batfet = bat_only && cd_low;

    // Long button hold counter
    if (btn_low)
    begin
      if (st_q.hold_cnt != HW'(RESET_HOLD_CYCLES))
      begin
        st_d.hold_cnt = st_q.hold_cnt + HW'(1);
      end
    end
    else
    begin
      st_d.hold_cnt = '0;
    end
    st_d.hold_done = btn_low && (st_q.hold_cnt == HW'(RESET_HOLD_CYCLES) - HW'(1));

    // Once disabled, the buck stays locked out until input or long hold
    st_d.en_prev = buck_output_enable;
    if (st_q.en_prev && !buck_output_enable)
    begin
      st_d.sys_lock = 1'b1;
    end
    else if (vin_valid || st_q.hold_done)
    begin
      st_d.sys_lock = 1'b0;
    end

    st_d.buck_sel = buck_range_select;
    st_d.buck_code = buck_voltage_code;

    unique case (st_q.buck_st)
      charger_ctrl_pkg::BUCK_OFF:
      begin
        if (buck_output_enable && !st_q.sys_lock)
        begin
          st_d.buck_st = charger_ctrl_pkg::BUCK_SOFT;
          st_d.soft_cnt = SW'(SOFTSTART_CYCLES);
        end
      end
      charger_ctrl_pkg::BUCK_SOFT:
      begin
        if (!buck_output_enable || st_q.sys_lock)
        begin
          st_d.buck_st = charger_ctrl_pkg::BUCK_OFF;
        end
        else if (st_q.soft_cnt == SW'(1))
        begin
          st_d.buck_st = charger_ctrl_pkg::BUCK_RUN;
        end
        else
        begin
          st_d.soft_cnt = st_q.soft_cnt - SW'(1);
        end
      end
      charger_ctrl_pkg::BUCK_RUN:
      begin
        if (!buck_output_enable || st_q.sys_lock)
        begin
          st_d.buck_st = charger_ctrl_pkg::BUCK_OFF;
        end
      end
      default:
      begin
        st_d.buck_st = charger_ctrl_pkg::BUCK_OFF;
      end
    endcase

    st_d.buck_ref = st_d.buck_st != charger_ctrl_pkg::BUCK_OFF;
    st_d.buck_soft = st_d.buck_st == charger_ctrl_pkg::BUCK_SOFT;
    st_d.buck_sw = st_d.buck_st != charger_ctrl_pkg::BUCK_OFF;
    st_d.buck_dis = st_d.buck_st == charger_ctrl_pkg::BUCK_OFF;

    // Aux output: chip-disable plays no part, so an enabled output stays on
    st_d.aux_mv = aux_mv_of(aux_output_voltage_code);
    if ((aux_output_enable_bit || aux_pin) && !aux_fault)
    begin
      if (st_d.aux_mv > charger_ctrl_pkg::AUX_PASS_MV)
      begin
        st_d.aux_md = charger_ctrl_pkg::AUX_LSW;
      end
      else
      begin
        st_d.aux_md = charger_ctrl_pkg::AUX_LDO;
      end
      st_d.aux_pd = 1'b0;
    end
    else
    begin
      st_d.aux_md = charger_ctrl_pkg::AUX_PULLDOWN;
      st_d.aux_pd = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_q <= '0;
      st_q.buck_st <= charger_ctrl_pkg::BUCK_OFF;
      st_q.buck_dis <= 1'b1;
      st_q.aux_md <= charger_ctrl_pkg::AUX_PULLDOWN;
      st_q.aux_pd <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign power_good_n_o = st_q.drive_lo;
  assign power_good_n_oe = st_q.pg_low;
  assign int_n_o = st_q.drive_lo;
  assign int_n_oe = st_q.int_low;
  assign button_mirror_mode = st_q.mirror;
  assign charge_enable = st_q.chg_en;
  assign hiz_mode = st_q.hiz;
  assign mid_power_rail_on = st_q.mid_on;
  assign batfet_on = st_q.batfet;
  assign buck_ref_on = st_q.buck_ref;
  assign buck_soft_start = st_q.buck_soft;
  assign buck_switching = st_q.buck_sw;
  assign buck_discharge = st_q.buck_dis;
  assign buck_range_o = st_q.buck_sel;
  assign buck_code_o = st_q.buck_code;
  assign aux_mode = st_q.aux_md;
  assign aux_target_mv = st_q.aux_mv;
  assign aux_pulldown_on = st_q.aux_pd;

endmodule // charger_status_output_ctrl

`default_nettype wire

/* dv/charger_status_output_ctrl_properties.sv */
// Concurrent checks on status pins, aux output and buck enable.
// Bound into the top module; pin inputs reach outputs 4 to 5 edges late.
`timescale 1ns/1ps
`default_nettype none

module charger_status_output_ctrl_checker #(
  parameter int unsigned FAULT_PULSE_CYCLES = 8
) (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire logic vin_above_uvlo, // Pin
  input wire logic vin_above_bat_slp, // Pin
  input wire logic vin_below_ovp, // Pin
  input wire logic push_button_in_n, // Pin
  input wire logic aux_output_pin_ctrl, // Pin
  input wire logic startup_done, // Start-up end
  input wire logic startup_fault, // Start-up verdict
  input wire logic charging_active, // Charging
  input wire logic fault_event, // Fault strobe
  input wire logic aux_fault, // Aux fault
  input wire logic charge_status_int_en, // Status enable
  input wire logic buck_output_enable, // Buck enable
  input wire logic aux_output_enable_bit, // Aux enable
  input wire logic power_good_n_oe, // Output
  input wire logic int_n_oe, // Output
  input wire logic button_mirror_mode, // Output
  input wire logic charge_enable, // Output
  input wire logic buck_switching, // Output
  input wire logic buck_discharge, // Output
  input wire logic [1:0] aux_mode, // Output
  input wire logic [11:0] aux_target_mv // Output
);
  logic done_q, started_q, vin_ok;
  logic [15:0] since_q;
  assign vin_ok = vin_above_uvlo && vin_above_bat_slp && vin_below_ovp;
  // Age of the last fault seen after a good start-up; saturates at the pulse length
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      done_q <= 1'b0;
      started_q <= 1'b0;
      since_q <= 16'(FAULT_PULSE_CYCLES);
    end
    else
    begin
      if (startup_done && !done_q)
      begin
        done_q <= 1'b1;
        started_q <= !startup_fault;
      end
      if (fault_event && started_q)
        since_q <= 16'h0000;
      else if (since_q < 16'(FAULT_PULSE_CYCLES))
        since_q <= since_q + 16'h0001;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  property p_pg_vin; !button_mirror_mode && power_good_n_oe |-> $past(vin_ok, 4) || $past(vin_ok, 5); endproperty
  a_pg_vin: assert property (p_pg_vin) else $error("power good without valid input");
  property p_pg_btn; button_mirror_mode && power_good_n_oe
    |-> !$past(push_button_in_n, 4) || !$past(push_button_in_n, 5); endproperty
  a_pg_btn: assert property (p_pg_btn) else $error("mirrored power good without button");
  property p_int_chg; $past(started_q) && $past(charging_active && charge_status_int_en && charge_enable)
    |-> int_n_oe; endproperty
  a_int_chg: assert property (p_int_chg) else $error("charging not shown on interrupt");
  property p_int_off; since_q >= 16'(FAULT_PULSE_CYCLES) && !$past(charge_status_int_en) |-> !int_n_oe; endproperty
  a_int_off: assert property (p_int_off) else $error("interrupt low with status disabled");
  property p_pulse; started_q && since_q < 16'(FAULT_PULSE_CYCLES) |-> int_n_oe; endproperty
  a_pulse: assert property (p_pulse) else $error("fault pulse too short");
  property p_quiet; !started_q |-> !power_good_n_oe && !int_n_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("status pin before good start-up");
  property p_buck_off; $fell(buck_output_enable) |=> !buck_switching && buck_discharge; endproperty
  a_buck_off: assert property (p_buck_off) else $error("buck not shut down");
  property p_aux_lsw; aux_mode != 2'b00 |-> (aux_mode == 2'b10) == (aux_target_mv > 12'h0ce4); endproperty
  a_aux_lsw: assert property (p_aux_lsw) else $error("aux mode does not match target");
  property p_aux_on; aux_mode != 2'b00 |-> !$past(aux_fault) && ($past(aux_output_enable_bit)
    || $past(aux_output_pin_ctrl, 4) || $past(aux_output_pin_ctrl, 5)); endproperty
  a_aux_on: assert property (p_aux_on) else $error("aux on without enable");
endmodule // charger_status_output_ctrl_checker

bind charger_status_output_ctrl charger_status_output_ctrl_checker #(
  .FAULT_PULSE_CYCLES(FAULT_PULSE_CYCLES)
) chk_u (
  .ref_clk, .rst, .vin_above_uvlo, .vin_above_bat_slp, .vin_below_ovp, .push_button_in_n,
  .aux_output_pin_ctrl, .startup_done, .startup_fault, .charging_active, .fault_event, .aux_fault,
  .charge_status_int_en, .buck_output_enable, .aux_output_enable_bit, .power_good_n_oe, .int_n_oe,
  .button_mirror_mode, .charge_enable, .buck_switching, .buck_discharge, .aux_mode, .aux_target_mv
);
`default_nettype wire

/* dv/host_mcu_model.sv */
// Host controller driving the button, chip-disable and aux control pins.
// Commands come from the bench; pins change on the falling edge.
`timescale 1ns/1ps
`default_nettype none

module host_mcu_model (
  input wire logic ref_clk, // Clock
  input wire logic btn_cmd, // Button level wanted
  input wire logic cd_drv, // Drive chip-disable
  input wire logic cd_cmd, // Chip-disable level
  input wire logic aux_cmd, // Aux control level
  output logic push_button_in_n, // Button pin
  output logic chip_disable_n, // Chip-disable pin
  output logic chip_disable_driven, // Host drives it
  output logic aux_output_pin_ctrl // Aux control pin
);
  logic cd_last;
  initial
  begin
    {push_button_in_n, chip_disable_n, chip_disable_driven, aux_output_pin_ctrl, cd_last} = 5'h10;
  end
  always @(negedge ref_clk)
  begin
    push_button_in_n <= btn_cmd;
    aux_output_pin_ctrl <= aux_cmd;
    chip_disable_driven <= cd_drv;
    cd_last <= cd_drv ? cd_cmd : cd_last;
    // Released line shows stale garbage; only the internal pull-down may decide
    chip_disable_n <= cd_drv ? cd_cmd : ~cd_last;
  end
endmodule // host_mcu_model
`default_nettype wire

/* dv/charger_status_output_ctrl_bench.sv */
// Self-checking bench of the charger status and output control block.
// Inputs change on the falling edge; long counts shortened by parameters.
`timescale 1ns/1ps
`default_nettype none

module charger_status_output_ctrl_bench;
  logic ref_clk, rst, battery_present, startup_done, startup_fault, charging_active, fault_event, aux_fault;
  logic status_pin_mirror_select, charge_status_int_en, buck_output_enable, aux_output_enable_bit;
  logic btn_cmd, cd_drv, cd_cmd, aux_cmd, push_button_in_n, chip_disable_n, chip_disable_driven;
  logic aux_output_pin_ctrl, power_good_n_oe, int_n_oe, button_mirror_mode, charge_enable, hiz_mode;
  logic mid_power_rail_on, batfet_on, buck_ref_on, buck_soft_start, buck_switching, buck_discharge;
  logic aux_pulldown_on, power_good_n_o, int_n_o;
  logic [2:0] vin;
  logic [1:0] buck_range_select, buck_range_o, aux_mode, e;
  logic [3:0] buck_voltage_code, buck_code_o;
  logic [4:0] aux_output_voltage_code;
  logic [11:0] aux_target_mv;
  logic [31:0] rng;
  int failures = 0, n_tests = 0, low_cnt = 0, n;
  charger_status_output_ctrl #(.FAULT_PULSE_CYCLES(8), .SOFTSTART_CYCLES(4), .RESET_HOLD_CYCLES(16)) dut_u (
    .ref_clk, .rst, .vin_above_uvlo(vin[0]), .vin_above_bat_slp(vin[1]), .vin_below_ovp(vin[2]),
    .battery_present, .push_button_in_n, .chip_disable_n, .chip_disable_driven, .aux_output_pin_ctrl,
    .startup_done, .startup_fault, .charging_active, .fault_event, .aux_fault, .status_pin_mirror_select,
    .charge_status_int_en, .buck_output_enable, .buck_range_select, .buck_voltage_code, .aux_output_enable_bit,
    .aux_output_voltage_code, .power_good_n_o, .power_good_n_oe, .int_n_o, .int_n_oe, .button_mirror_mode,
    .charge_enable, .hiz_mode, .mid_power_rail_on, .batfet_on, .buck_ref_on, .buck_soft_start, .buck_switching,
    .buck_discharge, .buck_range_o, .buck_code_o, .aux_mode, .aux_target_mv, .aux_pulldown_on);
  host_mcu_model host_u (.ref_clk, .btn_cmd, .cd_drv, .cd_cmd, .aux_cmd, .push_button_in_n, .chip_disable_n,
    .chip_disable_driven, .aux_output_pin_ctrl);
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) if (int_n_oe === 1'b1) low_cnt++;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [1:0] aux_exp(input logic on, input logic [4:0] code);
    if (!on)
      return 2'b00;
    return (12'h0320 + 12'h0064 * code > 12'h0ce4) ? 2'b10 : 2'b01;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic fpulse;
    fault_event = 1'b1;
    cyc(1);
    fault_event = 1'b0;
  endtask
  initial
  begin
    {rst, vin, battery_present, startup_done, startup_fault, charging_active, fault_event, aux_fault} = 10'h200;
    {status_pin_mirror_select, charge_status_int_en, buck_output_enable, aux_output_enable_bit} = 4'h0;
    {buck_range_select, buck_voltage_code, aux_output_voltage_code, btn_cmd, cd_drv, cd_cmd, aux_cmd} = 15'h0008;
    rng = 32'hbe7d;
    cyc(8);
    rst = 1'b0;
    chk({power_good_n_o, int_n_o, aux_pulldown_on, buck_discharge, power_good_n_oe, aux_mode}, 7'h18);
    // A faulty start-up must keep both status pins quiet even with a fault
    {vin, charging_active, charge_status_int_en, startup_fault, startup_done} = 7'h7f;
    cyc(1);
    startup_fault = 1'b0;
    fpulse();
    cyc(6);
    chk({int_n_oe, power_good_n_oe}, 2'b00);
    $display("test reset and faulty start-up done");
    {rst, startup_done, charging_active} = 3'h4;
    cyc(8);
    {rst, startup_done, battery_present} = 3'h3;
    for (int i = 0; i < 8; i++)
    begin
      vin = i[2:0];
      cyc(6);
      chk(power_good_n_oe, i == 7);
      chk({hiz_mode, batfet_on, mid_power_rail_on}, {i != 7, i != 7, 1'b1});
      chk(charge_enable, i == 7);
    end
    {cd_drv, cd_cmd} = 2'b11;
    cyc(6);
    chk(charge_enable, 1'b0);
    cd_drv = 1'b0;
    cyc(6);
    chk(charge_enable, 1'b1);
    status_pin_mirror_select = 1'b1;
    for (int b = 0; b < 2; b++)
    begin
      btn_cmd = b[0];
      cyc(6);
      chk({button_mirror_mode, power_good_n_oe}, {1'b1, !b[0]});
    end
    status_pin_mirror_select = 1'b0;
    $display("test power good and chip disable done");
    charging_active = 1'b1;
    cyc(4);
    chk(int_n_oe, 1'b1);
    charge_status_int_en = 1'b0;
    cyc(3);
    chk(int_n_oe, 1'b0);
    {charge_status_int_en, charging_active} = 2'b10;
    cyc(3);
    chk(int_n_oe, 1'b0);
    low_cnt = 0;
    fpulse();
    cyc(20);
    chk(low_cnt, 8);
    low_cnt = 0;
    fpulse();
    cyc(2);
    fpulse();
    cyc(20);
    chk(low_cnt, 11);
    $display("test interrupt done");
    for (int i = 0; i < 32; i++)
    begin
      rng = xs(rng);
      {aux_output_enable_bit, aux_cmd} = {rng[0] | (i < 2), rng[1]};
      aux_output_voltage_code = (i < 2) ? 5'(25 + i) : rng[6:2];
      aux_fault = (i > 1) && rng[9:7] == 3'h0;
      {cd_drv, cd_cmd, buck_range_select, buck_voltage_code} = rng[17:10];
      cyc(6);
      e = aux_exp((aux_output_enable_bit | aux_cmd) & !aux_fault, aux_output_voltage_code);
      chk(aux_mode, e);
      chk(aux_pulldown_on, e == 2'b00);
      chk(aux_target_mv, 12'h0320 + 12'h0064 * aux_output_voltage_code);
      chk({buck_range_o, buck_code_o}, rng[15:10]);
    end
    $display("test aux and buck fields done");
    {vin, cd_drv, buck_output_enable} = 5'h01;
    n = 0;
    for (int i = 0; i < 12; i++)
    begin
      cyc(1);
      n += (buck_soft_start === 1'b1);
    end
    chk(n, 4);
    chk({buck_ref_on, buck_switching}, 2'b11);
    buck_output_enable = 1'b0;
    cyc(2);
    chk({buck_switching, buck_discharge}, 2'b01);
    buck_output_enable = 1'b1;
    cyc(10);
    chk(buck_switching, 1'b0);
    {buck_output_enable, btn_cmd} = 2'b00;
    cyc(24);
    {buck_output_enable, btn_cmd} = 2'b11;
    n = 0;
    while (buck_switching !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    chk(buck_switching, 1'b1);
    $display("test buck enable done");
    complete_run();
  end
endmodule // charger_status_output_ctrl_bench
`default_nettype wire
